// ==== pdc_pkg.sv ====
package pdc_pkg;
	localparam int NUM_AXES = 2;
	localparam int SEL_W = 6;
	localparam int PW_W = 16;
	localparam int TICK_W = 18;
	localparam int HOLD_W = 4;
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_MS = 10;
	localparam logic [HOLD_W-1:0] HOLD_TICKS = HOLD_W'(HOLD_MS + 1);
	// register map
	localparam logic [31:0] REG_CTRL = 32'h0000_0000;
	localparam logic [31:0] REG_PWIDTH = 32'h0000_0004;
	localparam logic [31:0] REG_STATUS = 32'h0000_0008;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [PW_W-1:0] PW_RESET = 16'h0001;
	typedef enum logic [1:0] {
		MODE_INDEX = 2'b00,
		MODE_SCAN = 2'b01,
		MODE_CONT = 2'b10,
		MODE_PROG = 2'b11
	} pdc_mode_e;
	typedef enum logic [2:0] {
		AX_IDLE = 3'b000,
		AX_HOME = 3'b001,
		AX_MOVE = 3'b010,
		AX_PULSE = 3'b011,
		AX_HOLD = 3'b100
	} pdc_axis_e;
	typedef struct packed {
		logic single_axis;
		logic soft_limit_en;
		logic end_pulse_en;
	} pdc_ctrl_s;
	localparam pdc_ctrl_s CTRL_RESET = 3'h0;
	typedef struct packed {
		logic [NUM_AXES-1:0] axis;
		logic [SEL_W-1:0] step;
	} pdc_move_s;
	typedef struct packed {
		logic [NUM_AXES-1:0] move_busy;
		logic [NUM_AXES-1:0] homing;
		logic [NUM_AXES-1:0] out;
		logic [SEL_W-1:0] step;
		logic [1:0] mode;
	} pdc_status_s;
endpackage : pdc_pkg

// ==== pdc_in_sync.sv ====
`timescale 1ns/1ps
module pdc_in_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] pin_n,
	output logic [W-1:0] level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// open pin reads high
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= '1;
			s2 <= '1;
			s3 <= '1;
		end else begin
			s1 <= pin_n;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// shorted to common is asserted
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			level <= '0;
		end else begin
			for (int b = 0; b < W; b++) begin
				if (s2[b] == s3[b]) begin
					level[b] <= ~s3[b];
				end
			end
		end
	end
endmodule : pdc_in_sync

// ==== pdc_command_port.sv ====
// Summary of operation
// - mode inputs select index, scan, continuous, program
// - home requests accepted in every mode
// - input asserted when shorted; output when conducting
// - home starts after input held over 10 ms
// - no end pulse: output on during home search
// - end pulse: off during search, pulse at end
// - software limits suspended while homing
// - output released only after home input releases; the code clears it at move done for a move that ends without an end pulse
// - index mode: strobe starts selected stored move
// - six selector bits form step number 0-63
// - each axis designation input acts independently
// - single-axis build ignores second axis
// - move end-pulse flag gives end pulse
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module pdc_command_port #(
	parameter int MS_CYCLES = pdc_pkg::MS_CYCLES
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic mode_sel_lo_n,
	input wire logic mode_sel_hi_n,
	input wire logic home_n,
	input wire logic strobe_n,
	input wire logic [pdc_pkg::NUM_AXES-1:0] axis_sel_n,
	input wire logic [pdc_pkg::SEL_W-1:0] step_sel_n,
	output logic [pdc_pkg::NUM_AXES-1:0] axis_active_done,
	output pdc_pkg::pdc_mode_e drive_mode,
	output logic soft_limit_active,
	output logic [pdc_pkg::NUM_AXES-1:0] home_start,
	input wire logic [pdc_pkg::NUM_AXES-1:0] home_done,
	output logic move_start,
	output pdc_pkg::pdc_move_s move_req,
	input wire logic [pdc_pkg::NUM_AXES-1:0] move_done,
	input wire logic [pdc_pkg::NUM_AXES-1:0] move_end_flag
);
	localparam int NA = pdc_pkg::NUM_AXES;
	localparam int SW = pdc_pkg::SEL_W;
	localparam int IN_W = 4 + NA + SW;

	logic rst_meta;
	logic rst_n;
	logic [IN_W-1:0] in_lvl;
	logic mode_lo_q;
	logic mode_hi_q;
	logic home_q;
	logic strobe_q;
	logic [NA-1:0] axis_q;
	logic [SW-1:0] sel_q;
	logic [pdc_pkg::TICK_W-1:0] tick_cnt;
	logic ms_tick;
	logic [1:0] qual_lvl;
	logic [1:0] qual_ok;
	logic [1:0] qual_ok_d;
	logic [pdc_pkg::HOLD_W-1:0] hold_cnt [2];
	logic home_fire;
	logic strobe_fire;
	logic [NA-1:0] axis_en;
	logic [NA-1:0] home_go;
	logic [NA-1:0] move_go;
	logic [NA-1:0] out_q;
	logic [NA-1:0] homing;
	logic [NA-1:0] moving;
	pdc_pkg::pdc_ctrl_s ctrl;
	logic [pdc_pkg::PW_W-1:0] pulse_width;
	logic aw_hold;
	logic w_hold;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	pdc_pkg::pdc_status_s status;

	// reset release
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	pdc_in_sync #(.W(IN_W)) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.pin_n({mode_sel_lo_n, mode_sel_hi_n, home_n, strobe_n, axis_sel_n, step_sel_n}),
		.level(in_lvl)
	);
	assign {mode_lo_q, mode_hi_q, home_q, strobe_q, axis_q, sel_q} = in_lvl;

	always_comb begin
		drive_mode = pdc_pkg::pdc_mode_e'({mode_hi_q, mode_lo_q});
	end

	// millisecond tick
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= '0;
			ms_tick <= 1'b0;
		end else if (tick_cnt == pdc_pkg::TICK_W'(MS_CYCLES - 1)) begin
			tick_cnt <= '0;
			ms_tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
			ms_tick <= 1'b0;
		end
	end

	// hold qualification for home and strobe
	assign qual_lvl = {strobe_q, home_q};
	for (genvar q = 0; q < 2; q++) begin : g_qual
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				hold_cnt[q] <= '0;
			end else if (!qual_lvl[q]) begin
				hold_cnt[q] <= '0;
			end else if (ms_tick && hold_cnt[q] != pdc_pkg::HOLD_TICKS) begin
				hold_cnt[q] <= hold_cnt[q] + 1'b1;
			end
		end
		assign qual_ok[q] = qual_lvl[q] && hold_cnt[q] == pdc_pkg::HOLD_TICKS;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			qual_ok_d <= '0;
		end else begin
			qual_ok_d <= qual_ok;
		end
	end
	assign home_fire = qual_ok[0] && !qual_ok_d[0];
	assign strobe_fire = qual_ok[1] && !qual_ok_d[1];

	// per-axis start and drive/end output
	for (genvar i = 0; i < NA; i++) begin : g_axis
		pdc_pkg::pdc_axis_e st;
		logic [pdc_pkg::PW_W-1:0] pw_cnt;
		assign axis_en[i] = (i == 0) || !ctrl.single_axis;
		assign home_go[i] = home_fire && axis_q[i] && axis_en[i] && st == pdc_pkg::AX_IDLE;
		assign move_go[i] = strobe_fire && drive_mode == pdc_pkg::MODE_INDEX && axis_q[i] && axis_en[i]
			&& st == pdc_pkg::AX_IDLE && !home_go[i];
		assign homing[i] = st == pdc_pkg::AX_HOME;
		assign moving[i] = st == pdc_pkg::AX_MOVE;
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				st <= pdc_pkg::AX_IDLE;
				out_q[i] <= 1'b0;
				pw_cnt <= '0;
			end else if (!axis_en[i]) begin
				st <= pdc_pkg::AX_IDLE;
				out_q[i] <= 1'b0;
			end else begin
				case (st)
					pdc_pkg::AX_IDLE: begin
						if (home_go[i]) begin
							st <= pdc_pkg::AX_HOME;
							out_q[i] <= !ctrl.end_pulse_en;
						end else if (move_go[i]) begin
							st <= pdc_pkg::AX_MOVE;
							out_q[i] <= !ctrl.end_pulse_en;
						end
					end
					pdc_pkg::AX_HOME: begin
						if (home_done[i]) begin
							out_q[i] <= 1'b1;
							pw_cnt <= pulse_width;
							st <= ctrl.end_pulse_en ? pdc_pkg::AX_PULSE : pdc_pkg::AX_HOLD;
						end
					end
					pdc_pkg::AX_MOVE: begin
						if (move_done[i]) begin
							if (ctrl.end_pulse_en && move_end_flag[i]) begin
								out_q[i] <= 1'b1;
								pw_cnt <= pulse_width;
								st <= pdc_pkg::AX_PULSE;
							end else begin
								out_q[i] <= 1'b0;
								st <= pdc_pkg::AX_HOLD;
							end
						end
					end
					pdc_pkg::AX_PULSE: begin
						// whole ticks only, so the pulse never runs short of the width
						if (ms_tick) begin
							if (pw_cnt == '0) begin
								st <= pdc_pkg::AX_HOLD;
							end else begin
								pw_cnt <= pw_cnt - 1'b1;
							end
						end
					end
					pdc_pkg::AX_HOLD: begin
						if (!home_q) begin
							out_q[i] <= 1'b0;
							st <= pdc_pkg::AX_IDLE;
						end
					end
					default: begin
						st <= pdc_pkg::AX_IDLE;
						out_q[i] <= 1'b0;
					end
				endcase
			end
		end
	end

	assign axis_active_done = out_q & axis_en;
	assign soft_limit_active = ctrl.soft_limit_en && !(|homing);

	// start strobes to motion core
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			home_start <= '0;
			move_start <= 1'b0;
			move_req <= '0;
		end else begin
			home_start <= home_go;
			move_start <= |move_go;
			if (|move_go) begin
				move_req.axis <= move_go;
				move_req.step <= sel_q;
			end
		end
	end

	// register write channel
	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready = !w_hold && !s_axi_bvalid;
	assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pdc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr == pdc_pkg::REG_CTRL || aw_addr == pdc_pkg::REG_PWIDTH
					|| aw_addr == pdc_pkg::REG_STATUS) begin
					s_axi_bresp <= pdc_pkg::RESP_OKAY;
				end else begin
					s_axi_bresp <= pdc_pkg::RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= pdc_pkg::CTRL_RESET;
			pulse_width <= pdc_pkg::PW_RESET;
		end else if (wr_fire) begin
			if (aw_addr == pdc_pkg::REG_CTRL) begin
				if (w_strb[0]) begin
					ctrl <= pdc_pkg::pdc_ctrl_s'(w_data[2:0]);
				end
			end else if (aw_addr == pdc_pkg::REG_PWIDTH) begin
				if (w_strb[0]) begin
					pulse_width[7:0] <= w_data[7:0];
				end
				if (w_strb[1]) begin
					pulse_width[15:8] <= w_data[15:8];
				end
			end
		end
	end

	// register read channel
	assign status = '{move_busy: moving, homing: homing, out: axis_active_done, step: move_req.step, mode: drive_mode};
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= pdc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= pdc_pkg::RESP_OKAY;
			if (s_axi_araddr == pdc_pkg::REG_CTRL) begin
				s_axi_rdata <= 32'(ctrl);
			end else if (s_axi_araddr == pdc_pkg::REG_PWIDTH) begin
				s_axi_rdata <= 32'(pulse_width);
			end else if (s_axi_araddr == pdc_pkg::REG_STATUS) begin
				s_axi_rdata <= 32'(status);
			end else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= pdc_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// checks
	mode_decode_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(mode_lo_q && !mode_hi_q) |-> drive_mode == pdc_pkg::MODE_SCAN)
		else $error("mode decode wrong");
	home_any_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(home_fire && axis_q[0] && g_axis[0].st == pdc_pkg::AX_IDLE) |=> home_start[0])
		else $error("home request dropped");
	home_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		home_go[0] |-> hold_cnt[0] == pdc_pkg::HOLD_TICKS && $past(hold_cnt[0]) == pdc_pkg::HOLD_TICKS - 1'b1)
		else $error("home started before hold time");
	home_busy_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(home_go[0] && !ctrl.end_pulse_en) |=> axis_active_done[0] && homing[0])
		else $error("output not on at home start");
	home_pulse_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(homing[0] && ctrl.end_pulse_en && $past(homing[0])) |-> !axis_active_done[0])
		else $error("output on during pulsed home search");
	soft_limit_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(|homing) |-> !soft_limit_active)
		else $error("soft limit active while homing");
	release_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$fell(out_q[0]) && $past(g_axis[0].st) == pdc_pkg::AX_HOLD |-> !$past(home_q))
		else $error("output released while home held");
	index_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
		move_start |-> $past(drive_mode) == pdc_pkg::MODE_INDEX && $past(strobe_fire))
		else $error("move started outside index strobe");
	step_number_a: assert property (@(posedge mclk) disable iff (!rst_n)
		move_start |-> move_req.step == $past(sel_q))
		else $error("step number mismatch");
	single_axis_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ctrl.single_axis && $past(ctrl.single_axis)) |-> !axis_active_done[1] && (!move_start || !move_req.axis[1]))
		else $error("second axis acted in single-axis build");
	end_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(moving[0] && move_done[0] && ctrl.end_pulse_en && move_end_flag[0]) |=> axis_active_done[0])
		else $error("end pulse missing after move");
endmodule : pdc_command_port

// ==== pdc_switch_model.sv ====
`timescale 1ns/1ps
module pdc_switch_model (
	input wire logic [1:0] mode_on,
	input wire logic home_on,
	input wire logic strobe_on,
	input wire logic [pdc_pkg::NUM_AXES-1:0] axis_on,
	input wire logic [pdc_pkg::SEL_W-1:0] step_on,
	output logic mode_sel_lo_n,
	output logic mode_sel_hi_n,
	output logic home_n,
	output logic strobe_n,
	output logic [pdc_pkg::NUM_AXES-1:0] axis_sel_n,
	output logic [pdc_pkg::SEL_W-1:0] step_sel_n
);
	// closed contact pulls to common, open contact floats high on the pull-up
	assign mode_sel_lo_n = ~mode_on[0];
	assign mode_sel_hi_n = ~mode_on[1];
	assign home_n = ~home_on;
	assign strobe_n = ~strobe_on;
	assign axis_sel_n = ~axis_on;
	assign step_sel_n = ~step_on;
endmodule : pdc_switch_model

// ==== parallel_drive_command_port_test.sv ====
`timescale 1ns/1ps
module parallel_drive_command_port_test;
	localparam int MS = 20;
	logic mclk, nrst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] awaddr, wdata, araddr, rdata, r;
	logic [1:0] bresp, rresp, rsp, mode_on, axis_on, aad, hs, home_done, move_done, flag, axis_n;
	logic home_on, strobe_on, slim, mstart, lo_n, hi_n, home_n, strobe_n;
	logic [5:0] step_on, step_n;
	pdc_pkg::pdc_mode_e mode;
	pdc_pkg::pdc_move_s mreq;
	int mismatches, compares, n, cnt;
	pdc_command_port #(.MS_CYCLES(MS)) dut (.mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.mode_sel_lo_n(lo_n), .mode_sel_hi_n(hi_n), .home_n(home_n), .strobe_n(strobe_n),
		.axis_sel_n(axis_n), .step_sel_n(step_n), .axis_active_done(aad), .drive_mode(mode),
		.soft_limit_active(slim), .home_start(hs), .home_done(home_done), .move_start(mstart),
		.move_req(mreq), .move_done(move_done), .move_end_flag(flag));
	pdc_switch_model plc (.mode_on(mode_on), .home_on(home_on), .strobe_on(strobe_on), .axis_on(axis_on),
		.step_on(step_on), .mode_sel_lo_n(lo_n), .mode_sel_hi_n(hi_n), .home_n(home_n), .strobe_n(strobe_n),
		.axis_sel_n(axis_n), .step_sel_n(step_n));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task final_report;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report
	task stall;
		mismatches++;
		final_report();
	endtask : stall
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task cycles(input int k);
		repeat (k) @(negedge mclk);
	endtask : cycles
	task axi_wr(input logic [31:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		int i;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		for (i = 0; i < 50; i++) begin
			@(negedge mclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			rsp = bresp;
			@(posedge mclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) break;
		end
		bready <= 1'b0;
		if (i == 50) stall();
	endtask : axi_wr
	task axi_rd(input logic [31:0] a);
		logic ta, tr;
		int i;
		@(posedge mclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (i = 0; i < 50; i++) begin
			@(negedge mclk);
			ta = arvalid & arready;
			tr = rvalid;
			r = rdata;
			rsp = rresp;
			@(posedge mclk);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		rready <= 1'b0;
		if (i == 50) stall();
	endtask : axi_rd
	task wait_start(input bit mv);
		for (n = 0; n < 400; n++) begin
			@(negedge mclk);
			if (mv ? mstart : |hs) break;
		end
		if (n == 400) stall();
	endtask : wait_start
	task count_hi(input bit mv, input int k);
		cnt = 0;
		repeat (k) begin
			@(negedge mclk);
			cnt += mv ? mstart : aad[0];
		end
	endtask : count_hi
	task finish_op(input logic [1:0] h, input logic [1:0] m, input logic [1:0] f);
		@(posedge mclk);
		{home_done, move_done, flag} <= {h, m, f};
		@(posedge mclk);
		{home_done, move_done, flag} <= 6'h00;
	endtask : finish_op
	initial begin
		nrst = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, home_on, strobe_on} = '0;
		{awaddr, wdata, araddr} = '0;
		{mode_on, axis_on, home_done, move_done, flag, step_on} = '0;
		mismatches = 0;
		compares = 0;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		cycles(4);
		axi_rd(pdc_pkg::REG_CTRL);
		chk(r, 32'h0);
		chk(rsp, pdc_pkg::RESP_OKAY);
		axi_rd(pdc_pkg::REG_PWIDTH);
		chk(r, 32'h1);
		axi_rd(32'h10);
		chk(rsp, pdc_pkg::RESP_SLVERR);
		axi_wr(32'h10, 32'hFF);
		chk(rsp, pdc_pkg::RESP_SLVERR);
		for (int m = 0; m < 4; m++) begin
			@(posedge mclk) mode_on <= m[1:0];
			cycles(8);
			chk(mode, m);
		end
		@(posedge mclk) strobe_on <= 1'b1;
		axis_on <= 2'h1;
		count_hi(1, 300);
		chk(cnt, 0);
		@(posedge mclk) strobe_on <= 1'b0;
		axi_wr(pdc_pkg::REG_CTRL, 32'h2);
		chk(slim, 1);
		@(posedge mclk) axis_on <= 2'h1;
		@(posedge mclk) home_on <= 1'b1;
		wait_start(0);
		chk(n >= 10 * MS, 1);
		chk(hs, 2'h1);
		chk(aad, 2'h1);
		chk(slim, 0);
		finish_op(2'h1, 2'h0, 2'h0);
		cycles(10);
		chk(aad, 2'h1);
		@(posedge mclk) home_on <= 1'b0;
		cycles(12);
		chk(aad, 2'h0);
		@(posedge mclk) mode_on <= 2'h0;
		axis_on <= 2'h3;
		step_on <= 6'h25;
		@(posedge mclk) strobe_on <= 1'b1;
		wait_start(1);
		chk(n >= 10 * MS, 1);
		chk(mreq, 8'hE5);
		chk(aad, 2'h3);
		axi_rd(pdc_pkg::REG_STATUS);
		chk(r, 32'h3394);
		@(posedge mclk) strobe_on <= 1'b0;
		finish_op(2'h0, 2'h3, 2'h0);
		cycles(12);
		chk(aad, 2'h0);
		axi_wr(pdc_pkg::REG_CTRL, 32'h1);
		axi_wr(pdc_pkg::REG_PWIDTH, 32'h2);
		axi_rd(pdc_pkg::REG_PWIDTH);
		chk(r, 32'h2);
		@(posedge mclk) axis_on <= 2'h1;
		@(posedge mclk) home_on <= 1'b1;
		wait_start(0);
		cycles(20);
		chk(aad, 2'h0);
		@(posedge mclk) home_on <= 1'b0;
		finish_op(2'h1, 2'h0, 2'h0);
		count_hi(0, 120);
		chk(cnt >= 2 * MS && cnt <= 3 * MS + 2, 1);
		for (int f = 1; f >= 0; f--) begin
			@(posedge mclk) strobe_on <= 1'b1;
			wait_start(1);
			chk(aad, 2'h0);
			@(posedge mclk) strobe_on <= 1'b0;
			finish_op(2'h0, 2'h1, f[1:0]);
			count_hi(0, 120);
			chk(cnt >= 2 * MS * f && cnt <= (3 * MS + 2) * f, 1);
		end
		axi_wr(pdc_pkg::REG_CTRL, 32'h4);
		@(posedge mclk) axis_on <= 2'h3;
		@(posedge mclk) home_on <= 1'b1;
		wait_start(0);
		chk(hs, 2'h1);
		chk(aad, 2'h1);
		@(posedge mclk) home_on <= 1'b0;
		finish_op(2'h1, 2'h0, 2'h0);
		cycles(12);
		chk(aad, 2'h0);
		final_report();
	end
endmodule : parallel_drive_command_port_test
